// file: src/pmrs_defs.vh
// constants for the power-mode and reset sequencer
`ifndef PMRS_DEFS_VH
`define PMRS_DEFS_VH
// register byte offsets
`define PMRS_OFS_CTRL 12'h000
`define PMRS_OFS_MODE 12'h004
`define PMRS_OFS_STATUS 12'h008
`define PMRS_OFS_SUPPLY 12'h00c
`define PMRS_OFS_GUARD 12'h010
`define PMRS_OFS_WAKE 12'h014
// ctrl fields
`define PMRS_CTRL_LOCK 0
`define PMRS_CTRL_WDT_FAST 1
`define PMRS_CTRL_KEEP_WDOSC 2
`define PMRS_CTRL_KEEP_SDM 3
`define PMRS_CTRL_SUPPLY_IRQ_EN 4
`define PMRS_CTRL_RESET 5'h00
// low-power mode codes
`define PMRS_MODE_NONE 3'h0
`define PMRS_MODE_SLEEP 3'h1
`define PMRS_MODE_DSLEEP 3'h2
`define PMRS_MODE_PDOWN 3'h3
`define PMRS_MODE_DPD 3'h4
// status fields
`define PMRS_ST_SRC_PIN 0
`define PMRS_ST_SRC_WDT 1
`define PMRS_ST_SRC_POR 2
`define PMRS_ST_SRC_SDM 3
`define PMRS_ST_SUPPLY_LOW 4
`define PMRS_ST_DPD_REFUSED 5
`define PMRS_ST_DPD_WAKE 6
// reset values
`define PMRS_WAKE_MASK_RESET 8'h00
`define PMRS_SUPPLY_RESET 4'h0
`define PMRS_GUARD_RESET 2'h0
// timing
`define PMRS_CLK_MHZ 250
`define PMRS_PIN_PULSE_NS 50
// 50 ns at 250 MHz, rounded up to whole cycles
`define PMRS_PIN_PULSE_CYC 8'h0d
`define PMRS_DSLEEP_WAKE_CYC 8'h08
`define PMRS_PDOWN_WAKE_CYC 8'h40
`define PMRS_FLASH_INIT_CYC 8'h10
`define PMRS_IRC_MHZ 12
`endif

// file: src/pmrs_sequencer.v
// power-mode and reset sequencer with apb register slave
// Behaviour
// - after power-up or deep-off wake the fast internal oscillator clocks the chip
// - sleep stops only the core clock; leaving restarts it
// - sleep holds execution until reset or interrupt; peripherals keep running
// - deep-sleep stops core, peripheral clocks and sources except fast oscillator
// - deep-sleep gates fast oscillator output unless it clocks the watchdog
// - deep-sleep: analog off, flash standby, watchdog osc and monitor optional
// - deep-sleep exits on reset, selected pins, watchdog irq or usb activity
// - power-down stops all clocks except selected watchdog osc; analog, flash off
// - power-down exits on same sources; wake takes longer than deep-sleep
// - deep power-down removes power except deep-off exit pin, the only exit
// - lock bit refuses entry to deep power-down
// - chip reset from pin, watchdog, power-on or supply-drop monitor
// - any reset starts fast oscillator and initialises flash controller
// - reset pin low for 50 ns or more is a valid reset
// - on release core fetches from address 0 with registers at reset values; guard_reg and status_reg keep theirs
// - supply below selected level raises interrupt, also readable as status
// - supply below second selected threshold forces chip reset
// - guard level one blocks debug, limited programming except sector 0
// - guard level two blocks debug, only full erase and update programming
// - guard level three blocks debug, programming and boot-select entry
// - in-application programming works at every guard level
// - reset pin low selects boundary scan, high debug; debug off in reset
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "pmrs_defs.vh"
module pmrs_sequencer
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // reset sources
  input wire reset_pin_n,
  input wire watchdog_reset,
  input wire power_on_detect,
  // analog monitor levels: bit n high when supply below level n
  input wire [3:0] supply_below_irq_level,
  input wire [3:0] supply_below_rst_level,
  // core handshake
  input wire sleep_request,
  input wire irq_pending,
  // wake sources
  input wire [7:0] wake_pins,
  input wire watchdog_irq,
  input wire usb_activity_irq,
  input wire deep_off_exit_pin,
  // programming requests
  input wire boot_select_pin,
  // clock and power controls
  output reg core_clk_en,
  output reg periph_clk_en,
  output reg fast_osc_run,
  output reg fast_osc_out_en,
  output reg watchdog_osc_run,
  output reg analog_on,
  output reg flash_standby,
  output reg flash_on,
  output reg supply_monitor_on,
  output reg chip_power_on,
  output reg flash_init,
  output reg main_clk_sel_fast,
  // reset, boot and debug
  output reg chip_reset_n,
  output reg [31:0] boot_fetch_addr,
  output reg supply_irq,
  output reg debug_port_en,
  output reg boundary_scan_sel,
  output reg isp_enable,
  output reg isp_limited,
  output reg isp_full_erase_only,
  output reg isp_protect_sector0,
  output reg isp_boot_entry_en,
  output reg iap_enable
);
  localparam ST_RESET = 6'b000001;
  localparam ST_RUN = 6'b000010;
  localparam ST_SLEEP = 6'b000100;
  localparam ST_LOWPWR = 6'b001000;
  localparam ST_WAKE = 6'b010000;
  localparam ST_DPD = 6'b100000;
  localparam [7:0] PULSE_CYC = `PMRS_PIN_PULSE_CYC;
  localparam [7:0] DS_WAKE = `PMRS_DSLEEP_WAKE_CYC;
  localparam [7:0] PD_WAKE = `PMRS_PDOWN_WAKE_CYC;
  localparam [7:0] FLASH_CYC = `PMRS_FLASH_INIT_CYC;

  reg [5:0] state_reg;
  reg [2:0] lp_mode_reg;
  reg [2:0] mode_sel_reg;
  reg [4:0] ctrl_reg;
  reg [3:0] supply_sel_reg;
  reg [1:0] guard_reg;
  reg [7:0] wake_mask_reg;
  reg [6:0] status_reg;
  reg [7:0] pin_cnt_reg;
  reg [7:0] seq_cnt_reg;
  reg pin_low_reg;
  reg core_clk_en_next;
  reg periph_clk_en_next;
  reg fast_osc_run_next;
  reg fast_osc_out_en_next;
  reg watchdog_osc_run_next;
  reg analog_on_next;
  reg flash_standby_next;
  reg flash_on_next;
  reg supply_monitor_on_next;
  reg chip_power_on_next;
  reg flash_init_next;
  reg main_clk_sel_fast_next;
  reg supply_irq_next;
  reg debug_port_en_next;
  reg boundary_scan_sel_next;
  reg isp_enable_next;
  reg isp_limited_next;
  reg isp_full_erase_only_next;
  reg isp_protect_sector0_next;
  reg isp_boot_entry_en_next;

  wire apb_wr = psel & penable & pwrite & pready;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire pin_valid = ~reset_pin_n && pin_cnt_reg >= PULSE_CYC - 8'h01;
  wire irq_level = supply_below_irq_level[supply_sel_reg[1:0]];
  wire rst_level = supply_below_rst_level[supply_sel_reg[3:2]];
  wire any_reset = pin_valid | watchdog_reset | power_on_detect | rst_level;
  wire wake_any = (|(wake_pins & wake_mask_reg)) | watchdog_irq | usb_activity_irq;
  wire dpd_try = apb_wr && paddr == `PMRS_OFS_MODE && pwdata[2:0] == `PMRS_MODE_DPD;
  wire mapped = paddr == `PMRS_OFS_CTRL || paddr == `PMRS_OFS_MODE || paddr == `PMRS_OFS_STATUS ||
    paddr == `PMRS_OFS_SUPPLY || paddr == `PMRS_OFS_GUARD || paddr == `PMRS_OFS_WAKE;
  // state decode shared by the output logic
  wire st_reset = state_reg == ST_RESET;
  wire st_run = state_reg == ST_RUN;
  wire st_sleep = state_reg == ST_SLEEP;
  wire st_lowpwr = state_reg == ST_LOWPWR;
  wire st_dpd = state_reg == ST_DPD;

  // next output values; kept apart so every output stays a single flop
  always @*
  begin
    flash_init_next = st_reset;
    main_clk_sel_fast_next = st_reset | main_clk_sel_fast;
    core_clk_en_next = st_run;
    periph_clk_en_next = st_run | st_sleep;
    fast_osc_run_next = !st_dpd && !(st_lowpwr && lp_mode_reg == `PMRS_MODE_PDOWN);
    fast_osc_out_en_next = !st_dpd &&
      !(st_lowpwr && !(lp_mode_reg == `PMRS_MODE_DSLEEP && ctrl_reg[`PMRS_CTRL_WDT_FAST]));
    watchdog_osc_run_next = !st_dpd && ctrl_reg[`PMRS_CTRL_KEEP_WDOSC];
    analog_on_next = st_run | st_sleep;
    flash_standby_next = st_lowpwr && lp_mode_reg == `PMRS_MODE_DSLEEP;
    flash_on_next = !st_dpd && !(st_lowpwr && lp_mode_reg == `PMRS_MODE_PDOWN);
    supply_monitor_on_next = !st_dpd && (!st_lowpwr || ctrl_reg[`PMRS_CTRL_KEEP_SDM]);
    chip_power_on_next = !st_dpd;
    supply_irq_next = irq_level & ctrl_reg[`PMRS_CTRL_SUPPLY_IRQ_EN];
    boundary_scan_sel_next = ~reset_pin_n;
    debug_port_en_next = reset_pin_n && !st_reset && guard_reg == 2'h0;
    isp_enable_next = guard_reg != 2'h3;
    isp_limited_next = guard_reg == 2'h1;
    isp_protect_sector0_next = guard_reg == 2'h1;
    isp_full_erase_only_next = guard_reg == 2'h2;
    isp_boot_entry_en_next = guard_reg != 2'h3 && boot_select_pin;
  end

  // pin low-pulse width counter; glitches shorter than the minimum are ignored
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pin_cnt_reg <= 8'h00;
    else if (reset_pin_n)
      pin_cnt_reg <= 8'h00;
    else if (pin_cnt_reg != 8'hff)
      pin_cnt_reg <= pin_cnt_reg + 8'h01;
  end

  // apb slave: zero-wait answer; read data is loaded into a flop in the setup cycle
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (apb_rd)
      begin
        case (paddr)
          `PMRS_OFS_CTRL: prdata <= {27'h0, ctrl_reg};
          `PMRS_OFS_MODE: prdata <= {29'h0, mode_sel_reg};
          `PMRS_OFS_STATUS: prdata <= {25'h0, status_reg};
          `PMRS_OFS_SUPPLY: prdata <= {28'h0, supply_sel_reg};
          `PMRS_OFS_GUARD: prdata <= {30'h0, guard_reg};
          `PMRS_OFS_WAKE: prdata <= {24'h0, wake_mask_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration registers; chip reset restores all but guard_reg
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg <= `PMRS_CTRL_RESET;
      supply_sel_reg <= `PMRS_SUPPLY_RESET;
      guard_reg <= `PMRS_GUARD_RESET;
      wake_mask_reg <= `PMRS_WAKE_MASK_RESET;
    end
    else if (state_reg == ST_RESET)
    begin
      ctrl_reg <= `PMRS_CTRL_RESET;
      supply_sel_reg <= `PMRS_SUPPLY_RESET;
      wake_mask_reg <= `PMRS_WAKE_MASK_RESET;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `PMRS_OFS_CTRL: ctrl_reg <= pwdata[4:0];
        `PMRS_OFS_SUPPLY: supply_sel_reg <= pwdata[3:0];
        // guard level only rises until resetn, as flash programming would
        `PMRS_OFS_GUARD: guard_reg <= (pwdata[1:0] > guard_reg) ? pwdata[1:0] : guard_reg;
        `PMRS_OFS_WAKE: wake_mask_reg <= pwdata[7:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // status: sticky sources, set wins over write-one-to-clear
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      status_reg <= 7'h04;
    else
    begin
      status_reg[3:0] <= (status_reg[3:0] & ~((apb_wr && paddr == `PMRS_OFS_STATUS) ? pwdata[3:0] : 4'h0)) |
        {rst_level, power_on_detect, watchdog_reset, pin_valid};
      status_reg[`PMRS_ST_SUPPLY_LOW] <= irq_level;
      status_reg[`PMRS_ST_DPD_REFUSED] <= (status_reg[5] & ~(apb_wr && paddr == `PMRS_OFS_STATUS && pwdata[5])) |
        (dpd_try & ctrl_reg[`PMRS_CTRL_LOCK]);
      status_reg[`PMRS_ST_DPD_WAKE] <= (status_reg[6] & ~(apb_wr && paddr == `PMRS_OFS_STATUS && pwdata[6])) |
        (state_reg == ST_DPD && deep_off_exit_pin);
    end
  end

  // sequencer
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_RESET;
      mode_sel_reg <= `PMRS_MODE_NONE;
      lp_mode_reg <= `PMRS_MODE_NONE;
      seq_cnt_reg <= 8'h00;
    end
    else if (any_reset && state_reg != ST_DPD)
    begin
      state_reg <= ST_RESET;
      seq_cnt_reg <= 8'h00;
      mode_sel_reg <= `PMRS_MODE_NONE;
    end
    else
    begin
      if (apb_wr && paddr == `PMRS_OFS_MODE && !(dpd_try && ctrl_reg[`PMRS_CTRL_LOCK]))
        mode_sel_reg <= pwdata[2:0];
      case (state_reg)
        ST_RESET:
        begin
          if (seq_cnt_reg == FLASH_CYC - 8'h01)
            state_reg <= ST_RUN;
          else
            seq_cnt_reg <= seq_cnt_reg + 8'h01;
        end
        ST_RUN:
        begin
          seq_cnt_reg <= 8'h00;
          if (sleep_request && mode_sel_reg != `PMRS_MODE_NONE)
          begin
            lp_mode_reg <= mode_sel_reg;
            if (mode_sel_reg == `PMRS_MODE_SLEEP)
              state_reg <= ST_SLEEP;
            else if (mode_sel_reg == `PMRS_MODE_DPD)
              state_reg <= ST_DPD;
            else
              state_reg <= ST_LOWPWR;
          end
        end
        ST_SLEEP:
          if (irq_pending)
            state_reg <= ST_RUN;
        ST_LOWPWR:
          if (wake_any)
            state_reg <= ST_WAKE;
        ST_WAKE:
        begin
          // pdown restarts more blocks, so it waits longer
          if (seq_cnt_reg == ((lp_mode_reg == `PMRS_MODE_PDOWN) ? PD_WAKE : DS_WAKE) - 8'h01)
          begin
            state_reg <= ST_RUN;
            mode_sel_reg <= `PMRS_MODE_NONE;
          end
          else
            seq_cnt_reg <= seq_cnt_reg + 8'h01;
        end
        ST_DPD:
          if (deep_off_exit_pin)
          begin
            state_reg <= ST_RESET;
            seq_cnt_reg <= 8'h00;
            mode_sel_reg <= `PMRS_MODE_NONE;
          end
        default:
          state_reg <= ST_RESET;
      endcase
    end
  end

  // registered outputs
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      fast_osc_run <= 1'b1;
      fast_osc_out_en <= 1'b1;
      watchdog_osc_run <= 1'b0;
      analog_on <= 1'b0;
      flash_standby <= 1'b0;
      flash_on <= 1'b1;
      supply_monitor_on <= 1'b1;
      chip_power_on <= 1'b1;
      flash_init <= 1'b1;
      main_clk_sel_fast <= 1'b1;
      chip_reset_n <= 1'b0;
      boot_fetch_addr <= 32'h0000_0000;
      supply_irq <= 1'b0;
      debug_port_en <= 1'b0;
      boundary_scan_sel <= 1'b0;
      isp_enable <= 1'b0;
      isp_limited <= 1'b0;
      isp_full_erase_only <= 1'b0;
      isp_protect_sector0 <= 1'b0;
      isp_boot_entry_en <= 1'b0;
      iap_enable <= 1'b1;
    end
    else
    begin
      chip_reset_n <= (state_reg != ST_RESET);
      boot_fetch_addr <= 32'h0000_0000;
      flash_init <= flash_init_next;
      main_clk_sel_fast <= main_clk_sel_fast_next;
      core_clk_en <= core_clk_en_next;
      periph_clk_en <= periph_clk_en_next;
      fast_osc_run <= fast_osc_run_next;
      fast_osc_out_en <= fast_osc_out_en_next;
      watchdog_osc_run <= watchdog_osc_run_next;
      analog_on <= analog_on_next;
      flash_standby <= flash_standby_next;
      flash_on <= flash_on_next;
      supply_monitor_on <= supply_monitor_on_next;
      chip_power_on <= chip_power_on_next;
      supply_irq <= supply_irq_next;
      boundary_scan_sel <= boundary_scan_sel_next;
      debug_port_en <= debug_port_en_next;
      isp_enable <= isp_enable_next;
      isp_limited <= isp_limited_next;
      isp_protect_sector0 <= isp_protect_sector0_next;
      isp_full_erase_only <= isp_full_erase_only_next;
      isp_boot_entry_en <= isp_boot_entry_en_next;
      iap_enable <= 1'b1;
    end
  end
endmodule

// file: dv/pmrs_monitor.sv
// checker for the power-mode and reset sequencer ports
`timescale 1ns/10ps
module pmrs_monitor
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // reset and wake inputs
  input wire reset_pin_n,
  input wire watchdog_reset,
  input wire power_on_detect,
  input wire deep_off_exit_pin,
  // clock, power and debug outputs
  input wire core_clk_en,
  input wire periph_clk_en,
  input wire fast_osc_run,
  input wire fast_osc_out_en,
  input wire chip_power_on,
  input wire chip_reset_n,
  input wire [31:0] boot_fetch_addr,
  input wire debug_port_en,
  input wire boundary_scan_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // reset goes through the state and output registers, hence the slack
  sequence s_pin_held;
    !reset_pin_n [*8] ##1 !reset_pin_n [*5];
  endsequence
  sequence s_core_up;
    !core_clk_en ##1 core_clk_en;
  endsequence
  property p_pin_reset;
    s_pin_held |-> ##[0:6] !chip_reset_n;
  endproperty
  property p_src_reset;
    watchdog_reset || power_on_detect |-> ##[1:4] !chip_reset_n;
  endproperty
  property p_reset_osc;
    !chip_reset_n && chip_power_on |-> fast_osc_run;
  endproperty
  property p_boot;
    $rose(chip_reset_n) |-> boot_fetch_addr == 32'h0 && fast_osc_out_en;
  endproperty
  property p_dbg_reset;
    !chip_reset_n && $past(chip_reset_n) == 1'b0 |-> !debug_port_en;
  endproperty
  property p_scan;
    $fell(reset_pin_n) |-> ##[1:4] boundary_scan_sel;
  endproperty
  property p_dpd;
    !chip_power_on |-> !core_clk_en && !periph_clk_en && !fast_osc_run;
  endproperty
  property p_dpd_exit;
    !chip_power_on && deep_off_exit_pin |-> ##[1:4] chip_power_on;
  endproperty
  property p_clk_first;
    s_core_up |-> $past(fast_osc_run) && periph_clk_en;
  endproperty
  property p_periph_core;
    !periph_clk_en |-> !core_clk_en;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("held pin gave no reset");
  a_src_reset: assert property (p_src_reset) else $error("reset source ignored");
  a_reset_osc: assert property (p_reset_osc) else $error("oscillator off in reset");
  a_boot: assert property (p_boot) else $error("bad boot state");
  a_dbg_reset: assert property (p_dbg_reset) else $error("debug on in reset");
  a_scan: assert property (p_scan) else $error("scan not selected");
  a_dpd: assert property (p_dpd) else $error("clock alive without power");
  a_dpd_exit: assert property (p_dpd_exit) else $error("no exit from deep off");
  a_clk_first: assert property (p_clk_first) else $error("core clock before sources");
  a_periph_core: assert property (p_periph_core) else $error("core runs without peripherals");
endmodule
bind pmrs_sequencer pmrs_monitor pmrs_monitor_inst (.ref_clk(ref_clk), .resetn(resetn),
  .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset), .power_on_detect(power_on_detect),
  .deep_off_exit_pin(deep_off_exit_pin), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
  .fast_osc_run(fast_osc_run), .fast_osc_out_en(fast_osc_out_en), .chip_power_on(chip_power_on),
  .chip_reset_n(chip_reset_n), .boot_fetch_addr(boot_fetch_addr), .debug_port_en(debug_port_en),
  .boundary_scan_sel(boundary_scan_sel));

// file: dv/pmrs_partner.sv
// core model: sleep request and a delayed pending interrupt
`timescale 1ns/10ps
module pmrs_partner
#(
  parameter IRQ_DELAY = 20
)
(
  // clock and core clock gate
  input wire ref_clk,
  input wire core_clk_en,
  // commands from the bench
  input wire go_sleep,
  input wire irq_req,
  // to the sequencer
  output logic sleep_request = 1'b0,
  output logic irq_pending = 1'b0
);
  int wait_cnt = 0;
  always @(posedge ref_clk)
  begin
    // only a running core can ask to sleep
    sleep_request <= go_sleep && core_clk_en;
    wait_cnt <= irq_req ? wait_cnt + 1 : 0;
    irq_pending <= irq_req && wait_cnt >= IRQ_DELAY;
  end
endmodule

// file: dv/pmrs_sequencer_test.sv
// testbench for the power-mode and reset sequencer
`timescale 1ns/10ps
`include "pmrs_defs.vh"
module pmrs_sequencer_test;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, m, e; logic err;} pmrs_row_t;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rd_err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_val, boot_fetch_addr;
  logic reset_pin_n = 1, watchdog_reset = 0, power_on_detect = 0, boot_select_pin = 1;
  logic [3:0] supply_below_irq_level = 0, supply_below_rst_level = 0;
  logic [7:0] wake_pins = 0;
  logic watchdog_irq = 0, usb_activity_irq = 0, deep_off_exit_pin = 0, go_sleep = 0, irq_req = 0;
  logic sleep_request, irq_pending, core_clk_en, periph_clk_en, fast_osc_run, fast_osc_out_en;
  logic watchdog_osc_run, analog_on, flash_standby, flash_on, supply_monitor_on, chip_power_on;
  logic flash_init, main_clk_sel_fast, chip_reset_n, supply_irq, debug_port_en, boundary_scan_sel;
  logic isp_enable, isp_limited, isp_full_erase_only, isp_protect_sector0, isp_boot_entry_en, iap_enable;
  int mismatches = 0, cmp_count = 0, lat, lat_ds, cyc = 0;
  pmrs_row_t rows [0:10] = '{'{0, `PMRS_OFS_STATUS, 0, 'hf, 'h4, 0}, '{0, `PMRS_OFS_CTRL, 0, '1, 0, 0},
    '{0, `PMRS_OFS_MODE, 0, '1, 0, 0}, '{0, `PMRS_OFS_GUARD, 0, '1, 0, 0}, '{0, `PMRS_OFS_WAKE, 0, '1, 0, 0},
    '{0, `PMRS_OFS_SUPPLY, 0, '1, 0, 0}, '{1, `PMRS_OFS_CTRL, 'h1e, '1, 'h1e, 0},
    '{1, `PMRS_OFS_WAKE, 'hffffffa5, '1, 'ha5, 0}, '{1, `PMRS_OFS_SUPPLY, 'hd, '1, 'hd, 0},
    '{1, 12'h018, 'h1, 0, 0, 1}, '{0, 12'h7fc, 0, 0, 0, 1}};
  pmrs_sequencer pmrs_sequencer_inst (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_pin_n, .watchdog_reset, .power_on_detect, .supply_below_irq_level,
    .supply_below_rst_level, .sleep_request, .irq_pending, .wake_pins, .watchdog_irq, .usb_activity_irq,
    .deep_off_exit_pin, .boot_select_pin, .core_clk_en, .periph_clk_en, .fast_osc_run, .fast_osc_out_en,
    .watchdog_osc_run, .analog_on, .flash_standby, .flash_on, .supply_monitor_on, .chip_power_on, .flash_init,
    .main_clk_sel_fast, .chip_reset_n, .boot_fetch_addr, .supply_irq, .debug_port_en, .boundary_scan_sel,
    .isp_enable, .isp_limited, .isp_full_erase_only, .isp_protect_sector0, .isp_boot_entry_en, .iap_enable);
  pmrs_partner #(.IRQ_DELAY(20)) pmrs_partner_inst (.ref_clk, .core_clk_en, .go_sleep, .irq_req,
    .sleep_request, .irq_pending);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the bus waits on pready with no fixed latency; the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd_val & m, e);
  endtask
  task automatic wt(input logic s, input logic v);
    lat = 0;
    while (((s ? chip_reset_n : core_clk_en) !== v) && lat < 500)
    begin
      @(posedge ref_clk);
      lat++;
    end
    chk(lat < 500, 1);
  endtask
  task automatic lowpwr(input logic [2:0] md, input logic [4:0] c, input logic [2:0] s);
    apb(1, `PMRS_OFS_CTRL, c);
    apb(1, `PMRS_OFS_MODE, md);
    go_sleep <= 1;
    wt(0, 0);
    go_sleep <= 0;
    repeat (2) @(posedge ref_clk);
    chk(periph_clk_en, 0);
    chk(analog_on, 0);
    chk(flash_standby, md == 2);
    chk(fast_osc_run, md == 2);
    chk(fast_osc_out_en, md == 2 && c[1]);
    chk(watchdog_osc_run, c[2]);
    chk(supply_monitor_on, c[3]);
    {usb_activity_irq, watchdog_irq, wake_pins[0]} <= s;
    wt(0, 1);
    {usb_activity_irq, watchdog_irq, wake_pins[0]} <= 0;
    rd(`PMRS_OFS_MODE, 7, 0);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    chk(flash_init & fast_osc_run & !chip_reset_n, 1);
    resetn <= 1;
    wt(0, 1);
    chk(main_clk_sel_fast, 1);
    chk({boundary_scan_sel, debug_port_en}, 2'b01);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].m, rows[i].e);
      chk(rd_err, rows[i].err);
    end
    // sleep: peripherals stay up, core waits for the slow interrupt
    apb(1, `PMRS_OFS_MODE, 1);
    go_sleep <= 1;
    wt(0, 0);
    go_sleep <= 0;
    irq_req <= 1;
    chk(periph_clk_en & analog_on, 1);
    wt(0, 1);
    irq_req <= 0;
    chk(lat > 20, 1);
    apb(1, `PMRS_OFS_MODE, 0);
    lowpwr(2, 5'h1e, 3'b001);
    lat_ds = lat;
    lowpwr(2, 5'h00, 3'b100);
    lowpwr(3, 5'h04, 3'b010);
    chk(lat > lat_ds, 1);
    apb(1, `PMRS_OFS_CTRL, 1);
    apb(1, `PMRS_OFS_MODE, 4);
    go_sleep <= 1;
    repeat (8) @(posedge ref_clk);
    go_sleep <= 0;
    chk(chip_power_on & core_clk_en, 1);
    rd(`PMRS_OFS_STATUS, 'h20, 'h20);
    apb(1, `PMRS_OFS_CTRL, 0);
    apb(1, `PMRS_OFS_MODE, 4);
    go_sleep <= 1;
    wt(0, 0);
    go_sleep <= 0;
    wake_pins <= 8'hff;
    repeat (20) @(posedge ref_clk);
    chk(chip_power_on, 0);
    wake_pins <= 0;
    deep_off_exit_pin <= 1;
    wt(0, 1);
    deep_off_exit_pin <= 0;
    chk(main_clk_sel_fast, 1);
    rd(`PMRS_OFS_STATUS, 'h40, 'h40);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, `PMRS_OFS_STATUS, 'hf);
      apb(1, `PMRS_OFS_SUPPLY, 'h8);
      reset_pin_n <= k != 0;
      watchdog_reset <= k == 1;
      power_on_detect <= k == 2;
      supply_below_rst_level <= (k == 3) ? 4'h4 : 4'h0;
      wt(1, 0);
      chk({boundary_scan_sel, debug_port_en}, {k == 0, 1'b0});
      reset_pin_n <= 1;
      watchdog_reset <= 0;
      power_on_detect <= 0;
      supply_below_rst_level <= 0;
      wt(0, 1);
      rd(`PMRS_OFS_STATUS, 'hf, 32'h1 << k);
      rd(`PMRS_OFS_CTRL, 'h1f, 0);
    end
    apb(1, `PMRS_OFS_SUPPLY, 1);
    apb(1, `PMRS_OFS_CTRL, 'h10);
    supply_below_irq_level <= 4'hd;
    rd(`PMRS_OFS_STATUS, 'h10, 0);
    supply_below_irq_level <= 4'h2;
    repeat (4) @(posedge ref_clk);
    chk(supply_irq, 1);
    apb(1, `PMRS_OFS_CTRL, 0);
    rd(`PMRS_OFS_STATUS, 'h10, 'h10);
    for (int g = 0; g < 5; g++)
    begin
      apb(1, `PMRS_OFS_GUARD, g & 3);
      rd(`PMRS_OFS_GUARD, 3, (g > 3) ? 3 : g);
      chk(debug_port_en, g == 0);
      chk(isp_protect_sector0, g == 1);
      chk(isp_full_erase_only, g == 2);
      chk({isp_enable, isp_boot_entry_en}, (g < 3) ? 2'b11 : 2'b00);
      chk(iap_enable, 1);
    end
    print_verdict;
  end
endmodule
